// ### core/hbi_chain.sv
// three-stage interpolation chain with modulator output options and registers
// assumes AXI4-Lite masters keep one write and one read outstanding at most
//
// The AXI4-Lite interface to the registers was left to the implementer.

module hbi_chain import hbi_pkg::*; #(
   parameter logic [7:0] PART_ID = 8'ha5, // arbitrary value
   parameter int BUF_DEPTH = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sample_valid,
   input wire hbi_iq_type sample_data,
   output logic sample_ready,
   output logic dac_valid,
   output hbi_iq_type dac_data,
   input wire logic dac_ready
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [7:0] datapath_q;
   logic [7:0] stage1_ctrl_q;
   logic [7:0] stage2_ctrl_q;
   logic [7:0] stage3_ctrl_q;
   logic wr_start;
   logic rd_start;
   logic wr_fire;
   logic rd_fire;
   logic [7:0] wbyte;
   logic [7:0] status;
   logic dup_mode;
   logic low_side;
   hbi_iq_type in_word;
   logic buf_valid;
   hbi_iq_type buf_data;
   logic buf_ready;
   logic s1_valid;
   hbi_iq_type s1_data;
   logic s1_ready;
   logic s2_valid;
   hbi_iq_type s2_data;
   logic s2_ready;
   logic s3_valid;
   hbi_iq_type s3_data;
   logic s3_ready;
   logic [2:0] s1_step;
   logic [2:0] s2_step;
   logic [2:0] s3_step;
   logic [1:0] active_stages;

   // ------------------------------------------------------------
   // mode decoding
   // ------------------------------------------------------------

   // output option bits
   assign dup_mode = datapath_q[DUP_BIT];
   assign low_side = datapath_q[SIDEBAND_BIT];

   // first stage: code steps a quarter of its output rate,
   // upper code bit adds the half-turn shift by the input rate
   assign s1_step = {stage1_ctrl_q[MODE_LSB+1], stage1_ctrl_q[MODE_LSB], 1'b0};

   // later stages: the 3-bit half of the repeated code steps an
   // eighth of the output rate, its top bit is the modulation
   assign s2_step = stage2_ctrl_q[MODE_LSB+2:MODE_LSB];
   assign s3_step = stage3_ctrl_q[MODE_LSB+2:MODE_LSB];

   // number of stages in use, read back in the status register
   assign active_stages = 2'(!stage1_ctrl_q[BYPASS_BIT])
                        + 2'(!stage2_ctrl_q[BYPASS_BIT])
                        + 2'(!stage3_ctrl_q[BYPASS_BIT]);

   // status word: active stage count, buffer and output state
   assign status = {3'h0, !sample_ready, dac_valid, 1'b0, active_stages};

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------

   // accept address and data together once no response is pending
   assign wr_start = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
   assign wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
   assign wbyte = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;

   // one-cycle ready pulses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= wr_start;
         s_axi_wready <= wr_start;
      end
   end

   // write response, error for an address that decodes to nothing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         if (hbi_hit(s_axi_awaddr, IDX_DATAPATH) || hbi_hit(s_axi_awaddr, IDX_STAGE1)
             || hbi_hit(s_axi_awaddr, IDX_STAGE2) || hbi_hit(s_axi_awaddr, IDX_STAGE3)
             || hbi_hit(s_axi_awaddr, IDX_PART_ID) || hbi_hit(s_axi_awaddr, IDX_STATUS)) begin
            s_axi_bresp <= RESP_OKAY;
         end else begin
            s_axi_bresp <= RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------

   // output option register: sideband and I-to-Q duplicate
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         datapath_q <= CTRL_RESET;
      end else if (wr_fire && hbi_hit(s_axi_awaddr, IDX_DATAPATH) && s_axi_wstrb[0]) begin
         datapath_q <= wbyte & DP_MASK;
      end
   end

   // first-stage control: mode [2:1], bypass [0]
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage1_ctrl_q <= CTRL_RESET;
      end else if (wr_fire && hbi_hit(s_axi_awaddr, IDX_STAGE1) && s_axi_wstrb[0]) begin
         stage1_ctrl_q <= wbyte & S1_MASK;
      end
   end

   // second-stage control: mode [6:1], bypass [0]
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage2_ctrl_q <= CTRL_RESET;
      end else if (wr_fire && hbi_hit(s_axi_awaddr, IDX_STAGE2) && s_axi_wstrb[0]) begin
         stage2_ctrl_q <= wbyte & S23_MASK;
      end
   end

   // third-stage control: mode [6:1], bypass [0]
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage3_ctrl_q <= CTRL_RESET;
      end else if (wr_fire && hbi_hit(s_axi_awaddr, IDX_STAGE3) && s_axi_wstrb[0]) begin
         stage3_ctrl_q <= wbyte & S23_MASK;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------

   assign rd_start = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
   assign rd_fire = s_axi_arready && s_axi_arvalid;

   // one-cycle address ready pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= rd_start;
      end
   end

   // read data mux, narrow registers sit in the low byte
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         if (hbi_hit(s_axi_araddr, IDX_DATAPATH)) begin
            s_axi_rdata <= {24'h0, datapath_q};
         end else if (hbi_hit(s_axi_araddr, IDX_STAGE1)) begin
            s_axi_rdata <= {24'h0, stage1_ctrl_q};
         end else if (hbi_hit(s_axi_araddr, IDX_STAGE2)) begin
            s_axi_rdata <= {24'h0, stage2_ctrl_q};
         end else if (hbi_hit(s_axi_araddr, IDX_STAGE3)) begin
            s_axi_rdata <= {24'h0, stage3_ctrl_q};
         end else if (hbi_hit(s_axi_araddr, IDX_PART_ID)) begin
            s_axi_rdata <= {24'h0, PART_ID};
         end else if (hbi_hit(s_axi_araddr, IDX_STATUS)) begin
            s_axi_rdata <= {24'h0, status};
         end else begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // input buffer
   // ------------------------------------------------------------

   // incoming Q is dropped while duplicating I
   assign in_word = '{i: sample_data.i, q: (dup_mode ? 16'sh0000 : sample_data.q)};

   hbi_skid #(
      .W($bits(hbi_iq_type)),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(sample_valid),
      .in_data(in_word),
      .in_ready(sample_ready),
      .out_valid(buf_valid),
      .out_data(buf_data),
      .out_ready(buf_ready)
   );

   // ------------------------------------------------------------
   // interpolation stages, first to third
   // ------------------------------------------------------------

   // first stage
   hbi_stage u_stage1 (
      .aclk(aclk),
      .aresetn(aresetn),
      .bypass(stage1_ctrl_q[BYPASS_BIT]),
      .phase_step(s1_step),
      .hold_q(dup_mode),
      .in_valid(buf_valid),
      .in_data(buf_data),
      .in_ready(buf_ready),
      .out_valid(s1_valid),
      .out_data(s1_data),
      .out_ready(s1_ready)
   );

   // second stage runs at the first stage's output rate
   hbi_stage u_stage2 (
      .aclk(aclk),
      .aresetn(aresetn),
      .bypass(stage2_ctrl_q[BYPASS_BIT]),
      .phase_step(s2_step),
      .hold_q(dup_mode),
      .in_valid(s1_valid),
      .in_data(s1_data),
      .in_ready(s1_ready),
      .out_valid(s2_valid),
      .out_data(s2_data),
      .out_ready(s2_ready)
   );

   // third stage runs at the second stage's output rate
   hbi_stage u_stage3 (
      .aclk(aclk),
      .aresetn(aresetn),
      .bypass(stage3_ctrl_q[BYPASS_BIT]),
      .phase_step(s3_step),
      .hold_q(dup_mode),
      .in_valid(s2_valid),
      .in_data(s2_data),
      .in_ready(s2_ready),
      .out_valid(s3_valid),
      .out_data(s3_data),
      .out_ready(s3_ready)
   );

   // ------------------------------------------------------------
   // modulator output toward the converters
   // ------------------------------------------------------------

   assign s3_ready = !dac_valid || dac_ready;

   // duplicate mode copies I onto Q; otherwise low side conjugates the output
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dac_valid <= 1'b0;
         dac_data <= '0;
      end else if (s3_ready) begin
         dac_valid <= s3_valid;
         if (s3_valid && dup_mode) begin
            dac_data <= '{i: s3_data.i, q: s3_data.i};
         end else if (s3_valid && low_side) begin
            dac_data <= '{i: s3_data.i, q: -s3_data.q};
         end else if (s3_valid) begin
            dac_data <= s3_data;
         end
      end
   end

endmodule // hbi_chain

// ### core/hbi_pkg.sv
// shared constants, carrier types and helper math for the interpolation chain
// assumes one 40 MHz clock, synchronous active-low reset and an AXI4-Lite host
//
// Functional notes
// - sideband bit 0 gives the high-side image, 1 gives the spectrally inverted low-side image; a set duplicate bit overrides it.
// - the duplicate bit drops incoming Q, freezes the Q datapath and sends I to both outputs.
// - first-stage mode codes 00 and 01 are unmodulated, centred at 0 and 0.5 of its input rate.
// - first-stage mode codes 10 and 11 shift the signal by the stage input rate (1.0 and 1.5).
// - bit 0 of the first-stage control register bypasses that stage, default in use.
// - second-stage codes 000000 to 011011 are unmodulated, centres 0, 0.25, 0.5, 0.75 of rate.
// - second-stage codes 100100 to 111111 modulate by the input rate, centres 1.0 to 1.75.
// - bit 0 of the second-stage control register bypasses that stage, default in use.
// - third-stage codes 000000 to 011011 are unmodulated, centres 0, 0.25, 0.5, 0.75 of rate.
// - third-stage codes 100100 to 111111 modulate by the input rate, centres 1.0 to 1.75.
// - bit 0 of the third-stage control register bypasses that stage, default in use.
// - an eight-bit read-only register returns a fixed part identification value.

package hbi_pkg;

   // ------------------------------------------------------------
   // carrier
   // ------------------------------------------------------------
   typedef struct packed {
      logic signed [15:0] i;
      logic signed [15:0] q;
   } hbi_iq_type;

   // ------------------------------------------------------------
   // register map (index, byte address is four times the index)
   // ------------------------------------------------------------
   localparam int AXI_AW = 12;
   localparam logic [7:0] IDX_DATAPATH = 8'h1b;
   localparam logic [7:0] IDX_STAGE1 = 8'h1c;
   localparam logic [7:0] IDX_STAGE2 = 8'h1d;
   localparam logic [7:0] IDX_STAGE3 = 8'h1e;
   localparam logic [7:0] IDX_PART_ID = 8'h1f;
   localparam logic [7:0] IDX_STATUS = 8'h20;
   localparam int BYPASS_BIT = 0;
   localparam int MODE_LSB = 1;
   localparam int DUP_BIT = 0;
   localparam int SIDEBAND_BIT = 1;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] S1_MASK = 8'h07;
   localparam logic [7:0] S23_MASK = 8'h7f;
   localparam logic [7:0] DP_MASK = 8'h03;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // datapath constants
   // ------------------------------------------------------------
   localparam logic signed [15:0] COS45 = 16'sh5a82;

   // true when an AXI byte address selects register index idx
   function automatic logic hbi_hit(logic [AXI_AW-1:0] addr, logic [7:0] idx);
      return addr[AXI_AW-1:2] == {2'h0, idx};
   endfunction

   // keep the old Q part while the Q path is frozen
   function automatic hbi_iq_type hbi_keep_q(hbi_iq_type n, hbi_iq_type o, logic hold);
      return '{i: n.i, q: (hold ? o.q : n.q)};
   endfunction

   // midpoint of two samples, the interpolated tap of the short half-band
   function automatic hbi_iq_type hbi_avg(hbi_iq_type a, hbi_iq_type b);
      logic signed [16:0] si;
      logic signed [16:0] sq;
      si = (17'(a.i) + 17'(b.i)) >>> 1;
      sq = (17'(a.q) + 17'(b.q)) >>> 1;
      return '{i: si[15:0], q: sq[15:0]};
   endfunction

   // rotate by ph eighths of a turn; -32768 negation wraps
   function automatic hbi_iq_type hbi_rotate(hbi_iq_type x, logic [2:0] ph);
      hbi_iq_type r;
      logic signed [16:0] d;
      logic signed [16:0] s;
      logic signed [32:0] pd;
      logic signed [32:0] ps;
      d = 17'(x.i) - 17'(x.q);
      s = 17'(x.i) + 17'(x.q);
      pd = 33'(d) * 33'(COS45);
      ps = 33'(s) * 33'(COS45);
      r = x;
      if (ph[0]) begin
         r = '{i: pd[30:15], q: ps[30:15]};
      end
      unique case (ph[2:1])
         2'h0: return r;
         2'h1: return '{i: -r.q, q: r.i};
         2'h2: return '{i: -r.i, q: -r.q};
         2'h3: return '{i: r.q, q: -r.i};
      endcase
   endfunction

endpackage

// ### core/hbi_skid.sv
// two-entry buffer with valid and ready on both sides
// assumes depth is a power of two; input ready is registered
module hbi_skid import hbi_pkg::*; #(
   parameter int W = 32,
   parameter int DEPTH = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0] cnt_q;
   logic [PW:0] cnt_d;
   logic push;
   logic pop;

   // handshakes on each side
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_valid = cnt_q != '0;
   assign out_data = mem[rd_q];
   assign cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);

   // pointers and fill level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         in_ready <= 1'b0;
      end else begin
         wr_q <= wr_q + PW'(push);
         rd_q <= rd_q + PW'(pop);
         cnt_q <= cnt_d;
         in_ready <= cnt_d != (PW+1)'(DEPTH);
      end
   end

   // storage
   always_ff @(posedge aclk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end
endmodule // hbi_skid

// ### core/hbi_stage.sv
// one 2x half-band interpolation stage with output frequency shift
// assumes the step is in eighths of a turn per output sample
module hbi_stage import hbi_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic bypass,
   input wire logic [2:0] phase_step,
   input wire logic hold_q,
   input wire logic in_valid,
   input wire hbi_iq_type in_data,
   output logic in_ready,
   output logic out_valid,
   output hbi_iq_type out_data,
   input wire logic out_ready
);
   hbi_iq_type prev_q;
   hbi_iq_type cur_q;
   logic pend_q;
   logic [2:0] acc_q;
   logic advance;

   assign advance = !out_valid || out_ready;
   assign in_ready = advance && !pend_q;

   // two outputs per input unless bypassed: midpoint first, then the sample itself; one output per input in bypass
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_valid <= 1'b0;
         out_data <= '0;
         prev_q <= '0;
         cur_q <= '0;
         pend_q <= 1'b0;
         acc_q <= '0;
      end else if (advance) begin
         if (pend_q) begin
            out_data <= hbi_keep_q(hbi_rotate(cur_q, acc_q), out_data, hold_q);
            acc_q <= acc_q + phase_step;
            pend_q <= 1'b0;
            out_valid <= 1'b1;
         end else if (in_valid && bypass) begin
            out_data <= hbi_keep_q(in_data, out_data, hold_q);
            out_valid <= 1'b1;
         end else if (in_valid) begin
            out_data <= hbi_keep_q(hbi_rotate(hbi_avg(in_data, prev_q), acc_q),
                                   out_data, hold_q);
            acc_q <= acc_q + phase_step;
            prev_q <= hbi_keep_q(in_data, prev_q, hold_q);
            cur_q <= hbi_keep_q(in_data, cur_q, hold_q);
            pend_q <= 1'b1;
            out_valid <= 1'b1;
         end else begin
            out_valid <= 1'b0;
         end
      end
   end
endmodule // hbi_stage

// ### verif/hbi_chain_assertions.sv
// port checker for the interpolation chain, bound into hbi_chain
// assumes one clock and one write or read in flight at a time
module hbi_chk import hbi_pkg::*; #(
   parameter logic [7:0] PART_ID = 8'ha5
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic dac_valid,
   input wire hbi_iq_type dac_data,
   input wire logic dac_ready
);
   logic [7:0] dp_q, s1_q, s2_q, s3_q, exp_q;
   logic chk_q, bad_q;
   logic [9:0] wa, ra;
   assign wa = s_axi_awaddr[11:2];
   assign ra = s_axi_araddr[11:2];

   // shadow of the control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {dp_q, s1_q, s2_q, s3_q} <= '0;
      end else if (s_axi_awready && s_axi_wstrb[0]) begin
         if (wa == 10'h01b) dp_q <= s_axi_wdata[7:0] & 8'h03;
         if (wa == 10'h01c) s1_q <= s_axi_wdata[7:0] & 8'h07;
         if (wa == 10'h01d) s2_q <= s_axi_wdata[7:0] & 8'h7f;
         if (wa == 10'h01e) s3_q <= s_axi_wdata[7:0] & 8'h7f;
      end
   end

   // expected answer of the read just taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {chk_q, bad_q, exp_q} <= '0;
      end else if (s_axi_arready) begin
         chk_q <= ra >= 10'h01b && ra <= 10'h01f;
         bad_q <= ra < 10'h01b || ra > 10'h020;
         exp_q <= ra == 10'h01b ? dp_q : ra == 10'h01c ? s1_q : ra == 10'h01d ? s2_q :
                  ra == 10'h01e ? s3_q : PART_ID;
      end
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_aw_w_pair: assert property (s_axi_awready |-> s_axi_wready)
      else $error("write address and data not taken together");
   a_write_resp: assert property (s_axi_awready |=> s_axi_bvalid)
      else $error("write response late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_resp: assert property (s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_reg_read: assert property (s_axi_rvalid && chk_q |-> s_axi_rdata == {24'h0, exp_q} && s_axi_rresp == RESP_OKAY)
      else $error("register read value wrong");
   a_bad_read: assert property (s_axi_rvalid && bad_q |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_dup_copy: assert property (dac_valid && $changed(dac_data) && $past(dp_q[0]) |-> dac_data.q == dac_data.i)
      else $error("duplicate mode output differs");
   a_dac_hold: assert property (dac_valid && !dac_ready |=> dac_valid && $stable(dac_data))
      else $error("converter word changed while stalled");

   c_dup: cover property (dac_valid && $changed(dac_data) && $past(dp_q[0]));
   c_stall: cover property (dac_valid && !dac_ready);
   c_bad: cover property (s_axi_rvalid && bad_q);
endmodule // hbi_chk

bind hbi_chain hbi_chk #(.PART_ID(PART_ID)) u_chk (.*);

// ### verif/hbi_src.sv
// baseband sample source that feeds the chain's input port
// assumes the bench calls send right after a rising edge of aclk
module hbi_src import hbi_pkg::*; (
   input wire logic aclk,
   output logic valid,
   output hbi_iq_type data,
   input wire logic ready
);
   initial begin
      valid = 1'b0;
      data = '0;
   end

   // offer n words stepping both parts by inc, idle gap cycles after each
   task automatic send(input hbi_iq_type x, input int n, input logic [15:0] inc, input int gap);
      for (int k = 0; k < n; k++) begin
         valid <= 1'b1;
         data <= x;
         do @(posedge aclk); while (ready !== 1'b1);
         if (gap > 0 || k == n - 1) begin
            valid <= 1'b0;
            data <= ~x; // idle lines never repeat the last word
            repeat (gap) @(posedge aclk);
         end
         x = '{i: x.i + inc, q: x.q + inc};
      end
   endtask
endmodule // hbi_src

// ### verif/tb_halfband_interpolator_chain_config.sv
// self-checking bench for the interpolation chain
// assumes the package, design, source model and checker compile first
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_halfband_interpolator_chain_config import hbi_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] PID = 8'h3c; // arbitrary value
   typedef struct packed {logic [11:0] a; logic [7:0] w; logic [1:0] b; logic [7:0] r;} hbi_row_type;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic dac_ready = 1, awready, wready, bvalid, arready, rvalid, svalid, sready, dac_valid;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0] wstrb = 0;
   logic [1:0] bresp, rresp;
   hbi_iq_type sdata, dac_data;
   hbi_iq_type got[$];
   int err_total = 0, n_tests = 0, cyc = 0;
   hbi_row_type rows[6] = '{'{12'h070, 8'hff, 2'h0, 8'h07}, '{12'h074, 8'hff, 2'h0, 8'h7f},
      '{12'h078, 8'hff, 2'h0, 8'h7f}, '{12'h06c, 8'hff, 2'h0, 8'h03},
      '{12'h07c, 8'h00, 2'h0, PID}, '{12'h100, 8'h55, 2'h2, 8'h00}};

   hbi_chain #(.PART_ID(PID)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sample_valid(svalid), .sample_data(sdata), .sample_ready(sready),
      .dac_valid(dac_valid), .dac_data(dac_data), .dac_ready(dac_ready));
   hbi_src src (.aclk(aclk), .valid(svalid), .data(sdata), .ready(sready));

   always #12.5 aclk = ~aclk;

   // collect converter words and cut a hang short
   always @(posedge aclk) begin
      cyc++;
      if (dac_valid === 1'b1 && dac_ready === 1'b1) got.push_back(dac_data);
      if (cyc == 6000) begin
         err_total++;
         test_done();
      end
   end

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta = 0;
      logic tw = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) begin
            ta = 1;
            awvalid <= 0;
         end
         if (wready === 1'b1) begin
            tw = 1;
            wvalid <= 0;
         end
      end while (!(ta && tw && bvalid === 1'b1));
      r = bresp;
      bready <= 0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) begin
            ta = 1;
            arvalid <= 0;
         end
      end while (!(ta && rvalid === 1'b1));
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask

   task automatic cfg(input logic [7:0] dp, s1, s2, s3);
      logic [1:0] r;
      wr(12'h06c, {24'h0, dp}, r);
      wr(12'h070, {24'h0, s1}, r);
      wr(12'h074, {24'h0, s2}, r);
      wr(12'h078, {24'h0, s3}, r);
      got.delete();
   endtask

   task automatic wait_out(input int n);
      for (int k = 0; k < 800 && got.size() < n; k++) @(posedge aclk);
      repeat (30) @(posedge aclk);
      `CHK(got.size(), n)
   endtask

   // quarter turns of a complex sample
   function automatic hbi_iq_type rotq(hbi_iq_type x, int n);
      for (int k = 0; k < n % 4; k++) x = '{i: -x.q, q: x.i};
      return x;
   endfunction

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] v;
      int p;
      hbi_iq_type x;
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      // reset values of the control registers and the fixed identification
      for (int k = 0; k < 5; k++) begin
         rd(12'h06c + 12'(4 * k), d, r);
         `CHK(d, (k == 4) ? {24'h0, PID} : 32'h0)
      end
      // table rows: write, then read back
      foreach (rows[k]) begin
         wr(rows[k].a, {24'hffffff, rows[k].w}, r);
         `CHK(r, rows[k].b)
         rd(rows[k].a, d, r);
         `CHK({r, d}, {rows[k].b, 24'h0, rows[k].r})
      end
      // converter stalled until the input refuses, then drained in order
      cfg(8'h00, 8'h01, 8'h01, 8'h01);
      dac_ready <= 0;
      fork
         src.send(32'h0100fe00, 20, 16'h0011, 0);
      join_none
      repeat (60) @(posedge aclk);
      `CHK(sready, 1'b0)
      dac_ready <= 1;
      wait_out(20);
      for (int k = 0; k < 20; k++) `CHK(got[k], {16'h0100 + 16'(17 * k), 16'hfe00 + 16'(17 * k)})
      // sideband and duplicate options on a bypassed chain, slow source
      x = 32'h12340567;
      for (int k = 1; k < 4; k++) begin
         v = 8'(k);
         cfg(v, 8'h01, 8'h01, 8'h01);
         src.send(x, 4, 16'h0, 2);
         wait_out(4);
         `CHK(got[0], v[0] ? {x.i, x.i} : v[1] ? {x.i, -x.q} : x)
      end
      // each stage alone in each even mode code, output turns by code quarters
      x = 32'h10000800;
      for (int s = 0; s < 3; s++) begin
         for (int c = 0; c < 4; c++) begin
            v = (s == 0) ? 8'(c << 1) : {1'b0, 2'(c), 1'b0, 2'(c), 2'b00};
            cfg(8'h00, s == 0 ? v : 8'h01, s == 1 ? v : 8'h01, s == 2 ? v : 8'h01);
            src.send(x, 4, 16'h0, 0);
            wait_out(8);
            p = 0;
            while (p < 4 && rotq(x, p) !== got[2]) p++;
            `CHK(p < 4, 1'b1)
            for (int k = 3; k < 8; k++) `CHK(got[k], rotq(x, p + c * (k - 2)))
         end
      end
      // all three stages on: eight words per input
      cfg(8'h00, 8'h00, 8'h00, 8'h00);
      src.send(x, 2, 16'h0, 0);
      wait_out(16);
      test_done();
   end
endmodule // tb_halfband_interpolator_chain_config
